// >>> hw/iam_pkg.sv
/*
  Shared constants and carrier types for the indirect address mapper.
  Assumes one core clock in which one edge is one instruction cycle.
*/
package iam_pkg;

  localparam logic [15:0] TRAD_LAST   = 16'h0FFF;
  localparam logic [15:0] LIN_FIRST   = 16'h2000;
  localparam logic [15:0] LIN_LAST    = 16'h29AF;
  localparam logic [7:0]  EE_HIGH     = 8'h70;
  localparam logic [11:0] LIN_BLOCK   = 12'h050;
  localparam logic [11:0] GPR_BASE    = 12'h020;
  localparam logic [6:0]  IDP0_OFS    = 7'h00;
  localparam logic [6:0]  IDP1_OFS    = 7'h01;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam int          FLASH_WIDTH = 14;
  localparam int          LIN_BANKS   = 31;
  localparam logic [1:0]  NVM_EXTRA   = 2'h1;

  typedef enum logic [2:0] {
    IAM_RGN_NONE,
    IAM_RGN_SELF,
    IAM_RGN_TRAD,
    IAM_RGN_LIN,
    IAM_RGN_EE,
    IAM_RGN_FL
  } iam_region_t;

  typedef struct packed {
    logic       write;
    logic [7:0] ptr_high;
    logic [7:0] ptr_low;
    logic [7:0] wdata;
  } iam_req_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        re;
    logic        we;
    logic [7:0]  wdata;
  } iam_dmem_t;

endpackage : iam_pkg

// >>> hw/iam_mapper.sv
/*
  Indirect address mapper: turns a 16-bit indirect pointer into an
  access on banked data memory, data EEPROM or program flash.
  Assumes the execution logic and the memory arrays share core_clk,
  memories read synchronously (data one edge after re), and the
  requester holds off while busy is high.
*/
`timescale 1ns/10ps
`default_nettype none

module iam_mapper #(
  parameter int GPR_BANKS = iam_pkg::LIN_BANKS
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        req_valid,
  input  wire iam_pkg::iam_req_t           req,
  input  wire logic [7:0]                  dmem_rdata,
  input  wire logic [7:0]                  ee_rdata,
  input  wire logic [iam_pkg::FLASH_WIDTH-1:0] fl_rdata,
  output var  iam_pkg::iam_dmem_t          dmem,
  output logic [7:0]                       ee_addr,
  output logic                             ee_re,
  output logic [14:0]                      fl_addr,
  output logic                             fl_re,
  output logic [7:0]                       rdata,
  output logic                             done,
  output logic                             busy,
  output logic                             discard,
  output var  iam_pkg::iam_region_t        region
);

  typedef enum logic [1:0] {
    IAM_IDLE,
    IAM_ISSUE,
    IAM_FETCH,
    IAM_EXTRA
  } iam_state_t;

  // Registered outputs and their next values
  iam_state_t           state_reg;
  iam_state_t           state_next;
  iam_pkg::iam_dmem_t   dmem_reg;
  iam_pkg::iam_dmem_t   dmem_next;
  logic [7:0]           ee_addr_reg;
  logic [7:0]           ee_addr_next;
  logic                 ee_re_reg;
  logic                 ee_re_next;
  logic [14:0]          fl_addr_reg;
  logic [14:0]          fl_addr_next;
  logic                 fl_re_reg;
  logic                 fl_re_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic                 done_reg;
  logic                 done_next;
  logic                 busy_reg;
  logic                 busy_next;
  logic                 discard_reg;
  logic                 discard_next;
  iam_pkg::iam_region_t region_reg;
  iam_pkg::iam_region_t region_next;

  // What the taken request asked for, held until done
  logic                 write_reg;
  logic                 write_next;
  logic [1:0]           wait_reg;
  logic [1:0]           wait_next;

  // Decode of the live request, only meaningful while req_valid is high
  logic [15:0]          ptr;
  logic                 ptr_port;
  iam_pkg::iam_region_t dec_region;
  logic [11:0]          lin_offset;
  logic [4:0]           lin_bank;
  logic [6:0]           lin_index;
  logic [11:0]          lin_addr;
  logic                 lin_impl;

  // Pointer as one 16-bit address
  assign ptr = {req.ptr_high, req.ptr_low};

  // Linear offset split into bank and index within the 80-byte block.
  // A constant divider is cheap next to the memory it fronts.
  assign lin_offset = 12'(ptr - iam_pkg::LIN_FIRST);
  assign lin_bank   = 5'(lin_offset / iam_pkg::LIN_BLOCK);
  assign lin_index  = 7'(lin_offset % iam_pkg::LIN_BLOCK);

  // Block starts above the special registers and stops short of the
  // common bytes, so those never show up here.
  assign lin_addr = 12'({lin_bank, 7'h00}) + iam_pkg::GPR_BASE
                    + 12'(lin_index);

  // Banks from GPR_BANKS upward have no RAM behind them and read as zero
  assign lin_impl = (32'(lin_bank) < GPR_BANKS);

  // Offsets 0x00 and 0x01 of every bank are the two port registers
  assign ptr_port = (ptr[6:0] == iam_pkg::IDP0_OFS) || (ptr[6:0] == iam_pkg::IDP1_OFS);

  // Region decode, flash first since it claims the whole upper half
  always_comb begin
    if (ptr[15]) begin
      dec_region = iam_pkg::IAM_RGN_FL;
    end else if (req.ptr_high == iam_pkg::EE_HIGH) begin
      // Read-only window; the high byte alone selects it
      dec_region = iam_pkg::IAM_RGN_EE;
    end else if (ptr >= iam_pkg::LIN_FIRST && ptr <= iam_pkg::LIN_LAST) begin
      dec_region = iam_pkg::IAM_RGN_LIN;
    end else if (ptr <= iam_pkg::TRAD_LAST) begin
      // A port that points at itself would loop, so it reads zero instead
      if (ptr_port) begin
        dec_region = iam_pkg::IAM_RGN_SELF;
      end else begin
        dec_region = iam_pkg::IAM_RGN_TRAD;
      end
    end else begin
      dec_region = iam_pkg::IAM_RGN_NONE;
    end
  end

  // Sequencer: strobes and done are one-cycle pulses, the rest hold
  always_comb begin
    state_next   = state_reg;
    dmem_next    = dmem_reg;
    ee_addr_next = ee_addr_reg;
    ee_re_next   = 1'b0;
    fl_addr_next = fl_addr_reg;
    fl_re_next   = 1'b0;
    rdata_next   = rdata_reg;
    done_next    = 1'b0;
    busy_next    = busy_reg;
    discard_next = discard_reg;
    region_next  = region_reg;
    write_next   = write_reg;
    wait_next    = wait_reg;
    // Strobes fall back to low unless a take raises them
    dmem_next.re = 1'b0;
    dmem_next.we = 1'b0;

    unique case (state_reg)
      IAM_IDLE: begin
        // Only idle takes a request; one that comes while busy is lost
        if (req_valid) begin
          state_next   = IAM_ISSUE;
          busy_next    = 1'b1;
          region_next  = dec_region;
          write_next   = req.write;
          discard_next = 1'b0;
          wait_next    = 2'h0;
          unique case (dec_region)
            iam_pkg::IAM_RGN_TRAD: begin
              // Real location instead of a port register
              dmem_next.addr  = ptr[11:0];
              dmem_next.re    = ~req.write;
              dmem_next.we    = req.write;
              dmem_next.wdata = req.wdata;
            end

            iam_pkg::IAM_RGN_LIN: begin
              if (lin_impl) begin
                dmem_next.addr  = lin_addr;
                dmem_next.re    = ~req.write;
                dmem_next.we    = req.write;
                dmem_next.wdata = req.wdata;
              end else begin
                discard_next = 1'b1;
              end
            end

            iam_pkg::IAM_RGN_EE: begin
              ee_addr_next = req.ptr_low;
              ee_re_next   = ~req.write;
              discard_next = req.write;
              if (!req.write) begin
                wait_next = iam_pkg::NVM_EXTRA;
              end
            end

            // Flash answers a whole word; the port passes on its low byte
            iam_pkg::IAM_RGN_FL: begin
              fl_addr_next = ptr[14:0];
              fl_re_next   = ~req.write;
              discard_next = req.write;
              wait_next    = iam_pkg::NVM_EXTRA;
            end

            iam_pkg::IAM_RGN_SELF: begin
              discard_next = 1'b1;
            end

            iam_pkg::IAM_RGN_NONE: begin
              discard_next = 1'b1;
            end
          endcase
        end
      end

      IAM_ISSUE: begin
        // Arrays answer one edge after the strobe
        state_next = IAM_FETCH;
      end

      IAM_FETCH: begin
        // Read data is captured as soon as the array presents it, so
        // the array need not hold it through the extra cycle.
        if (write_reg || discard_reg) begin
          rdata_next = iam_pkg::ZERO_BYTE;
        end else begin
          unique case (region_reg)
            iam_pkg::IAM_RGN_TRAD: rdata_next = dmem_rdata;
            iam_pkg::IAM_RGN_LIN:  rdata_next = dmem_rdata;
            iam_pkg::IAM_RGN_EE:   rdata_next = ee_rdata;
            iam_pkg::IAM_RGN_FL:   rdata_next = fl_rdata[7:0];
            iam_pkg::IAM_RGN_SELF: rdata_next = iam_pkg::ZERO_BYTE;
            iam_pkg::IAM_RGN_NONE: rdata_next = iam_pkg::ZERO_BYTE;
          endcase
        end
        // Nonvolatile reads and flash writes spend one more cycle here
        if (wait_reg != 2'h0) begin
          state_next = IAM_EXTRA;
          wait_next  = 2'(wait_reg - 2'h1);
        end else begin
          state_next = IAM_IDLE;
          done_next  = 1'b1;
          busy_next  = 1'b0;
        end
      end

      IAM_EXTRA: begin
        // Stall cycle only; rdata was captured in fetch
        if (wait_reg != 2'h0) begin
          wait_next = 2'(wait_reg - 2'h1);
        end else begin
          state_next = IAM_IDLE;
          done_next  = 1'b1;
          busy_next  = 1'b0;
        end
      end
    endcase
  end

  // State and outputs only; all decisions sit in the process above
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= IAM_IDLE;
      dmem_reg    <= '0;
      ee_addr_reg <= 8'h00;
      ee_re_reg   <= 1'b0;
      fl_addr_reg <= 15'h0000;
      fl_re_reg   <= 1'b0;
      rdata_reg   <= 8'h00;
      done_reg    <= 1'b0;
      busy_reg    <= 1'b0;
      discard_reg <= 1'b0;
      region_reg  <= iam_pkg::IAM_RGN_NONE;
      write_reg   <= 1'b0;
      wait_reg    <= 2'h0;
    end else begin
      state_reg   <= state_next;
      dmem_reg    <= dmem_next;
      ee_addr_reg <= ee_addr_next;
      ee_re_reg   <= ee_re_next;
      fl_addr_reg <= fl_addr_next;
      fl_re_reg   <= fl_re_next;
      rdata_reg   <= rdata_next;
      done_reg    <= done_next;
      busy_reg    <= busy_next;
      discard_reg <= discard_next;
      region_reg  <= region_next;
      write_reg   <= write_next;
      wait_reg    <= wait_next;
    end
  end

  // Every output is a register, so the far side sees no decode glitches
  assign dmem    = dmem_reg;
  assign ee_addr = ee_addr_reg;
  assign ee_re   = ee_re_reg;
  assign fl_addr = fl_addr_reg;
  assign fl_re   = fl_re_reg;
  assign rdata   = rdata_reg;
  assign done    = done_reg;
  assign busy    = busy_reg;
  assign discard = discard_reg;
  assign region  = region_reg;

endmodule : iam_mapper

`default_nettype wire

// >>> dv/iam_mem_model.sv
/* Memory arrays behind the mapper: data RAM, EEPROM and flash.
   Assumes reads answer one edge after the strobe, content derived from address. */
`timescale 1ns/10ps
`default_nettype none
module iam_mem_model (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire iam_pkg::iam_dmem_t dmem,
  input  wire logic [7:0]         ee_addr,
  input  wire logic               ee_re,
  input  wire logic [14:0]        fl_addr,
  input  wire logic               fl_re,
  output var  logic [7:0]         dmem_rdata,
  output var  logic [7:0]         ee_rdata,
  output var  logic [13:0]        fl_rdata
);
  // Data holds one cycle only, then toggles so a late sample is caught
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmem_rdata <= 8'h00;
      ee_rdata   <= 8'h00;
      fl_rdata   <= 14'h0000;
    end else begin
      dmem_rdata <= dmem.re ? (dmem.addr[7:0] ^ 8'h5A) : ~dmem_rdata;
      ee_rdata   <= ee_re ? (ee_addr ^ 8'hC3) : ~ee_rdata;
      fl_rdata   <= fl_re ? {fl_addr[13:8], fl_addr[7:0] ^ 8'h3C} : ~fl_rdata;
    end
  end
endmodule : iam_mem_model
`default_nettype wire

// >>> dv/iam_mapper_sva.sv
/* Checker for the indirect address mapper ports.
   Assumes done counts 3 edges for data space, 4 for flash and EEPROM reads. */
`timescale 1ns/10ps
`default_nettype none
module iam_mapper_sva #(
  parameter int GPR_BANKS = 31
) (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 req_valid,
  input wire iam_pkg::iam_req_t    req,
  input wire logic [7:0]           dmem_rdata,
  input wire logic [7:0]           ee_rdata,
  input wire logic [13:0]          fl_rdata,
  input wire iam_pkg::iam_dmem_t   dmem,
  input wire logic [7:0]           ee_addr,
  input wire logic                 ee_re,
  input wire logic [14:0]          fl_addr,
  input wire logic                 fl_re,
  input wire logic [7:0]           rdata,
  input wire logic                 done,
  input wire logic                 busy,
  input wire logic                 discard,
  input wire iam_pkg::iam_region_t region
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic [15:0] ptr      = {req.ptr_high, req.ptr_low};
  wire logic [15:0] off      = ptr - 16'h2000;
  wire logic [11:0] lin_addr = 12'((off / 80) * 128 + 32 + off % 80);
  wire logic        take     = req_valid && !busy;
  wire logic        trad     = ptr < 16'h1000 && ptr[6:0] > 7'h01;
  wire logic        lin      = ptr >= 16'h2000 && off < 16'(80 * GPR_BANKS);
  wire logic        ee       = req.ptr_high == 8'h70;
  wire logic        fl       = ptr[15];
  wire logic        quiet    = !dmem.re && !dmem.we && !ee_re && !fl_re && discard;
  wire logic [2:0]  rgn      = fl ? iam_pkg::IAM_RGN_FL : ee ? iam_pkg::IAM_RGN_EE
                             : (ptr >= 16'h2000 && ptr <= 16'h29AF) ? iam_pkg::IAM_RGN_LIN
                             : trad ? iam_pkg::IAM_RGN_TRAD
                             : ptr < 16'h1000 ? iam_pkg::IAM_RGN_SELF : iam_pkg::IAM_RGN_NONE;
  sequence mem_wait; !done [*2] ##1 done; endsequence
  sequence nvm_wait; !done [*3] ##1 done; endsequence
  chk_trad_access: assert property (take && trad |=> {4'h0, dmem.addr} == $past(ptr)
    && dmem.we == $past(req.write) && dmem.re == !dmem.we && !discard
    && (!dmem.we || dmem.wdata == $past(req.wdata))
    ##0 mem_wait ##0 rdata == ($past(req.write, 3) ? 8'h00 : $past(dmem_rdata)))
    else $error("data space access wrong");
  chk_lin_map: assert property (take && lin |=> dmem.addr == $past(lin_addr) && (dmem.re || dmem.we)
    && !discard && (!dmem.we || dmem.wdata == $past(req.wdata)) ##0 mem_wait) else $error("linear address wrong");
  chk_zero_drop: assert property (take && !trad && !lin && !ee && !fl |=> quiet ##0 mem_wait ##0 rdata == 8'h00)
    else $error("dropped access not silent");
  chk_ee_read: assert property (take && ee && !req.write |=> ee_re && ee_addr == $past(req.ptr_low)
    && !discard ##0 nvm_wait ##0 rdata == $past(ee_rdata, 2)) else $error("eeprom read wrong");
  chk_ee_write: assert property (take && ee && req.write |=> quiet ##0 mem_wait ##0 rdata == 8'h00)
    else $error("eeprom write not dropped");
  chk_fl_read: assert property (take && fl && !req.write |=> fl_re && {1'b1, fl_addr} == $past(ptr)
    && !discard ##0 nvm_wait ##0 rdata == 8'($past(fl_rdata, 2))) else $error("flash read wrong");
  chk_fl_write: assert property (take && fl && req.write |=> quiet ##0 nvm_wait)
    else $error("flash write not dropped");
  chk_busy_stall: assert property (take |=> busy [*2] ##[1:2] (done && !busy))
    else $error("busy stall wrong");
  chk_region_code: assert property (take |=> busy && region == $past(rgn))
    else $error("region code wrong");
endmodule : iam_mapper_sva
`default_nettype wire

// >>> dv/tb_iam_mapper.sv
/* Self-checking bench for the indirect address mapper.
   Assumes the memory model answers with address-derived data. */
`timescale 1ns/10ps
`default_nettype none
module tb_iam_mapper;
  localparam int GPR_BANKS = 30;  // One bank short so unbacked linear reads occur
  logic                 core_clk  = 1'b0;
  logic                 sys_rst   = 1'b1;
  logic                 req_valid = 1'b0;
  iam_pkg::iam_req_t    req       = '0;
  logic [7:0]           dmem_rdata, ee_rdata, ee_addr, rdata;
  logic [13:0]          fl_rdata;
  logic [14:0]          fl_addr;
  logic                 ee_re, fl_re, done, busy, discard;
  iam_pkg::iam_dmem_t   dmem;
  iam_pkg::iam_region_t region;
  int                   n_mismatch = 0;
  int                   n_compared = 0;
  iam_mapper #(.GPR_BANKS(GPR_BANKS)) u_iam_mapper (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .dmem_rdata(dmem_rdata), .ee_rdata(ee_rdata), .fl_rdata(fl_rdata),
    .dmem(dmem), .ee_addr(ee_addr), .ee_re(ee_re), .fl_addr(fl_addr), .fl_re(fl_re), .rdata(rdata),
    .done(done), .busy(busy), .discard(discard), .region(region));
  iam_mem_model u_iam_mem_model (.core_clk(core_clk), .sys_rst(sys_rst), .dmem(dmem), .ee_addr(ee_addr),
    .ee_re(ee_re), .fl_addr(fl_addr), .fl_re(fl_re), .dmem_rdata(dmem_rdata), .ee_rdata(ee_rdata),
    .fl_rdata(fl_rdata));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Issues one request, counts edges to done, then judges data and latency
  task automatic access(input logic wr, input logic [15:0] p, input logic [7:0] exp, input logic [7:0] edges);
    logic [7:0] n;
    n = 8'h00;
    req_valid <= 1'b1;
    req       <= '{wr, p[15:8], p[7:0], 8'hA5};
    @(posedge core_clk);
    req_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 8'h08);
    check(rdata, exp);
    check(n, edges);
  endtask : access
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic t_trad;
    access(1'b0, 16'h0123, 8'h79, 8'h03);
    access(1'b1, 16'h0FFF, 8'h00, 8'h03);
    access(1'b0, 16'h0FFF, 8'hA5, 8'h03);
    access(1'b0, 16'h0080, 8'h00, 8'h03);
    access(1'b1, 16'h0F81, 8'h00, 8'h03);
    $display("test trad done");
  endtask : t_trad
  task automatic t_lin;
    access(1'b0, 16'h2000, 8'h7A, 8'h03);
    access(1'b0, 16'h204F, 8'h35, 8'h03);
    access(1'b0, 16'h2050, 8'hFA, 8'h03);
    access(1'b0, 16'h2910, 8'hFA, 8'h03);
    access(1'b0, 16'h29AF, 8'h00, 8'h03);
    access(1'b1, 16'h2050, 8'h00, 8'h03);
    access(1'b1, 16'h29A0, 8'h00, 8'h03);
    $display("test linear done");
  endtask : t_lin
  task automatic t_nvm;
    access(1'b0, 16'h7000, 8'hC3, 8'h04);
    access(1'b0, 16'h70FF, 8'h3C, 8'h04);
    access(1'b1, 16'h7010, 8'h00, 8'h03);
    access(1'b0, 16'h8000, 8'h3C, 8'h04);
    access(1'b0, 16'hFFFF, 8'hC3, 8'h04);
    access(1'b1, 16'h8123, 8'h00, 8'h04);
    $display("test nvm done");
  endtask : t_nvm
  task automatic t_none;
    access(1'b0, 16'h1000, 8'h00, 8'h03);
    access(1'b0, 16'h29B0, 8'h00, 8'h03);
    access(1'b0, 16'h7100, 8'h00, 8'h03);
    access(1'b1, 16'h7FFF, 8'h00, 8'h03);
    $display("test unmapped done");
  endtask : t_none
  // Reset in mid-run clears rdata, busy, done, discard and region, and the next request still goes through
  task automatic t_reset;
    req_valid <= 1'b1;
    req       <= '{1'b0, 8'h80, 8'h00, 8'hA5};
    @(posedge core_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(rdata, 8'h3C);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(rdata, 8'h00);
    check({5'h00, busy, done, discard}, 8'h00);
    check(8'(region), 8'(iam_pkg::IAM_RGN_NONE));
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check({5'h00, busy, done, discard}, 8'h00);
    access(1'b0, 16'h0123, 8'h79, 8'h03);
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_trad();
    t_lin();
    t_nvm();
    t_none();
    t_reset();
    results();
  end
  // Tests need about 125 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
endmodule : tb_iam_mapper
bind iam_mapper iam_mapper_sva #(.GPR_BANKS(GPR_BANKS)) u_iam_mapper_sva (.core_clk(core_clk),
  .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .dmem_rdata(dmem_rdata), .ee_rdata(ee_rdata),
  .fl_rdata(fl_rdata), .dmem(dmem), .ee_addr(ee_addr), .ee_re(ee_re), .fl_addr(fl_addr), .fl_re(fl_re),
  .rdata(rdata), .done(done), .busy(busy), .discard(discard), .region(region));
`default_nettype wire
